// file: clkmode_pkg.sv
package clkmode_pkg;
	// Register port widths and counter width
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int CNT_W = 16;
	// Register byte addresses
	localparam logic [7:0] ADDR_CLOCK_CTRL = 8'h8f;
	localparam logic [7:0] ADDR_T2_CONTROL = 8'hc8;
	localparam logic [7:0] ADDR_T2_MODE = 8'hc9;
	localparam logic [7:0] ADDR_RELOAD_LOW = 8'hca;
	localparam logic [7:0] ADDR_RELOAD_HIGH = 8'hcb;
	localparam logic [7:0] ADDR_COUNT_LOW = 8'hcc;
	localparam logic [7:0] ADDR_COUNT_HIGH = 8'hcd;
	// Reset values and counter top value
	localparam logic [7:0] RST_BYTE = 8'h00;
	localparam logic [15:0] RST_COUNT = 16'h0000;
	localparam logic [15:0] COUNT_MAX = 16'hffff;
	// Field positions in the clock control register
	localparam int BIT_SPEED_DOUBLE = 0;
	// Field positions in the timer 2 control register
	localparam int BIT_T2_FLAG = 7;
	localparam int BIT_T2_EXT_FLAG = 6;
	localparam int BIT_RX_BAUD = 5;
	localparam int BIT_TX_BAUD = 4;
	localparam int BIT_EXT_EN = 3;
	localparam int BIT_T2_RUN = 2;
	localparam int BIT_COUNTER_SEL = 1;
	localparam int BIT_CAPTURE_SEL = 0;
	// Field positions in the timer 2 mode register
	localparam int BIT_CLKOUT_EN = 1;
	localparam int BIT_DOWN_EN = 0;
	localparam logic [7:0] MODE_MASK = 8'h03;
	localparam logic [7:0] CLOCK_CTRL_MASK = 8'h01;
	// Oscillator periods per machine cycle
	localparam logic [3:0] OSC_PER_MC_12 = 4'hc;
	localparam logic [3:0] OSC_PER_MC_6 = 4'h6;
	localparam logic [3:0] MC_ONE = 4'h1;
	// Machine cycles the reset pin must be held
	localparam int RESET_MC = 2;
	localparam logic [4:0] RESET_OSC_12 = 5'(RESET_MC * 12);
	localparam logic [4:0] RESET_OSC_6 = 5'(RESET_MC * 6);
	// Clock period in ns at 40 MHz
	localparam int CLOCK_PERIOD_NS = 25;
endpackage : clkmode_pkg

// file: clock_mode_and_clockout.sv
// Chosen here: the plain strobed port.
`timescale 1ns/1ps
// Notes on behaviour
// - Speed bit clear and fuse erased gives 12-clock mode, the default.
// - Writing the speed bit to one selects 6-clock mode.
// - Speed bit is readable by software at any time and writable at any time except while sys_reset is held.
// - In 6-clock mode the machine cycle, internal Timer 2 tick and reset hold are half their 12-clock length.
// - Programmed fuse forces 6-clock mode whatever the speed bit says.
// - Clock-out pin can drive a 50% duty clock instead of port use.
// - Clock-out pin can instead feed Timer 2 as external count clock.
// - Clock-out frequency is oscillator over n times (65536 minus reload).
// - Reload value is high and low reload bytes as unsigned 16 bits.
// - Timer 2 roll-overs raise no interrupt in clock-out mode.
// - Baud generation and clock-out may run together at one rate.
// - Reset takes effect after pin high for two machine cycles.
module clock_mode_and_clockout (
	input wire logic clock,
	input wire logic nrst,
	input wire logic [clkmode_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [clkmode_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	output logic [clkmode_pkg::DATA_W-1:0] reg_rdata,
	input wire logic nv_speed_fuse,
	input wire logic reset_pin,
	output logic sys_reset,
	output logic six_clock_mode,
	output logic machine_tick,
	output logic baud_tick,
	output logic timer2_irq,
	input wire logic clkout_pin_in,
	output logic clkout_pin_out,
	output logic clkout_pin_oe
);
	import clkmode_pkg::*;

	logic [7:0] clock_ctrl_reg_q, clock_ctrl_reg_d;
	logic [7:0] t2_control_q, t2_control_d;
	logic [7:0] t2_mode_q, t2_mode_d;
	logic [15:0] reload_q, reload_d;
	logic [15:0] count_q, count_d;
	logic [7:0] rdata_q, rdata_d;
	logic [3:0] mc_cnt_q, mc_cnt_d;
	logic half_q, half_d;
	logic pin_prev_q, pin_prev_d;
	logic toggle_q, toggle_d;
	logic baud_q, baud_d;
	logic [4:0] rst_cnt_q, rst_cnt_d;
	logic sys_reset_q, sys_reset_d;

	logic speed_double_bit;
	logic six_mode;
	logic [3:0] mc_period;
	logic [4:0] rst_limit;
	logic mc_tick;
	logic fast_tick;
	logic ext_fall;
	logic timer2_run;
	logic timer2_counter_select;
	logic clkout_enable;
	logic clkout_mode;
	logic baud_mode;
	logic fast_mode;
	logic t2_tick;
	logic overflow;
	logic wr_t2_control;

	// Mode decode from the registers
	assign speed_double_bit = clock_ctrl_reg_q[BIT_SPEED_DOUBLE];
	assign timer2_run = t2_control_q[BIT_T2_RUN];
	assign timer2_counter_select = t2_control_q[BIT_COUNTER_SEL];
	assign clkout_enable = t2_mode_q[BIT_CLKOUT_EN];
	assign baud_mode = t2_control_q[BIT_RX_BAUD] | t2_control_q[BIT_TX_BAUD];
	assign wr_t2_control = reg_write && (reg_addr == ADDR_T2_CONTROL);

	assign six_mode = nv_speed_fuse | speed_double_bit;

	assign mc_period = six_mode ? OSC_PER_MC_6 : OSC_PER_MC_12;
	assign mc_tick = (mc_cnt_q >= mc_period - MC_ONE);

	assign fast_tick = six_mode | half_q;

	assign ext_fall = pin_prev_q & ~clkout_pin_in;

	assign clkout_mode = clkout_enable & ~timer2_counter_select;
	assign fast_mode = clkout_mode | baud_mode;

	always_comb
	begin
		if (!timer2_run)
			t2_tick = 1'b0;
		else if (timer2_counter_select)
			t2_tick = ext_fall;
		else if (fast_mode)
			t2_tick = fast_tick;
		else
			t2_tick = mc_tick;
	end

	assign overflow = t2_tick && (count_q == COUNT_MAX);

	// Prescalers and edge history
	always_comb
	begin
		mc_cnt_d = mc_tick ? 4'h0 : mc_cnt_q + MC_ONE;
		half_d = six_mode ? 1'b0 : ~half_q;
		pin_prev_d = clkout_pin_in;
		if (sys_reset_q)
		begin
			mc_cnt_d = 4'h0;
			half_d = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			mc_cnt_q <= 4'h0;
			half_q <= 1'b0;
			pin_prev_q <= 1'b0;
		end
		else
		begin
			mc_cnt_q <= mc_cnt_d;
			half_q <= half_d;
			pin_prev_q <= pin_prev_d;
		end
	end

	assign rst_limit = six_mode ? RESET_OSC_6 : RESET_OSC_12;
	always_comb
	begin
		rst_cnt_d = 5'h00;
		if (reset_pin)
			rst_cnt_d = (rst_cnt_q >= rst_limit) ? rst_cnt_q : rst_cnt_q + 5'h01;
		sys_reset_d = reset_pin && (sys_reset_q || rst_cnt_d >= rst_limit);
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_cnt_q <= 5'h00;
			sys_reset_q <= 1'b0;
		end
		else
		begin
			rst_cnt_q <= rst_cnt_d;
			sys_reset_q <= sys_reset_d;
		end
	end

	// Register writes, counter and clock-out state
	always_comb
	begin
		clock_ctrl_reg_d = clock_ctrl_reg_q;
		t2_control_d = t2_control_q;
		t2_mode_d = t2_mode_q;
		reload_d = reload_q;
		count_d = count_q;
		toggle_d = toggle_q;
		baud_d = overflow && baud_mode;
		if (reg_write && reg_addr == ADDR_CLOCK_CTRL)
			clock_ctrl_reg_d = reg_wdata & CLOCK_CTRL_MASK;
		if (wr_t2_control)
			t2_control_d = reg_wdata;
		if (reg_write && reg_addr == ADDR_T2_MODE)
			t2_mode_d = reg_wdata & MODE_MASK;
		if (reg_write && reg_addr == ADDR_RELOAD_LOW)
			reload_d[7:0] = reg_wdata;
		if (reg_write && reg_addr == ADDR_RELOAD_HIGH)
			reload_d[15:8] = reg_wdata;
		if (overflow)
			count_d = reload_q;
		else if (t2_tick)
			count_d = count_q + 16'h0001;
		if (reg_write && reg_addr == ADDR_COUNT_LOW)
			count_d[7:0] = reg_wdata;
		if (reg_write && reg_addr == ADDR_COUNT_HIGH)
			count_d[15:8] = reg_wdata;
		// flag only outside clock-out and baud use
		if (overflow && !fast_mode)
			t2_control_d[BIT_T2_FLAG] = 1'b1;
		if (overflow && clkout_mode)
			toggle_d = ~toggle_q;
		if (sys_reset_q)
		begin
			clock_ctrl_reg_d = RST_BYTE;
			t2_control_d = RST_BYTE;
			t2_mode_d = RST_BYTE;
			reload_d = RST_COUNT;
			count_d = RST_COUNT;
			toggle_d = 1'b0;
			baud_d = 1'b0;
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
		begin
			clock_ctrl_reg_q <= RST_BYTE;
			t2_control_q <= RST_BYTE;
			t2_mode_q <= RST_BYTE;
			reload_q <= RST_COUNT;
			count_q <= RST_COUNT;
			toggle_q <= 1'b0;
			baud_q <= 1'b0;
		end
		else
		begin
			clock_ctrl_reg_q <= clock_ctrl_reg_d;
			t2_control_q <= t2_control_d;
			t2_mode_q <= t2_mode_d;
			reload_q <= reload_d;
			count_q <= count_d;
			toggle_q <= toggle_d;
			baud_q <= baud_d;
		end
	end

	// Read data one cycle after the strobe; unmapped reads give zero
	always_comb
	begin
		rdata_d = RST_BYTE;
		if (reg_read)
		begin
			unique case (reg_addr)
				ADDR_CLOCK_CTRL: rdata_d = clock_ctrl_reg_q;
				ADDR_T2_CONTROL: rdata_d = t2_control_q;
				ADDR_T2_MODE: rdata_d = t2_mode_q;
				ADDR_RELOAD_LOW: rdata_d = reload_q[7:0];
				ADDR_RELOAD_HIGH: rdata_d = reload_q[15:8];
				ADDR_COUNT_LOW: rdata_d = count_q[7:0];
				ADDR_COUNT_HIGH: rdata_d = count_q[15:8];
				default: rdata_d = RST_BYTE;
			endcase
		end
	end

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			rdata_q <= RST_BYTE;
		else
			rdata_q <= rdata_d;
	end

	// Outputs
	assign reg_rdata = rdata_q;
	assign sys_reset = sys_reset_q;
	assign six_clock_mode = six_mode;
	assign machine_tick = mc_tick;
	assign baud_tick = baud_q;
	assign timer2_irq = t2_control_q[BIT_T2_FLAG];
	// pin driven only in clock-out mode
	assign clkout_pin_out = toggle_q;
	assign clkout_pin_oe = clkout_mode;

	mode_default_a: assert property (@(posedge clock) disable iff (!nrst)
		(!nv_speed_fuse && !speed_double_bit) |-> (!six_mode && mc_period == OSC_PER_MC_12))
		else $error("slow mode not selected by default");
	mode_double_a: assert property (@(posedge clock) disable iff (!nrst)
		(reg_write && reg_addr == ADDR_CLOCK_CTRL && reg_wdata[BIT_SPEED_DOUBLE] && !sys_reset_q)
		|=> six_clock_mode)
		else $error("speed bit write did not select fast mode");
	speed_readback_a: assert property (@(posedge clock) disable iff (!nrst)
		(reg_write && reg_addr == ADDR_CLOCK_CTRL && !sys_reset_q)
		##1 (reg_read && reg_addr == ADDR_CLOCK_CTRL && !sys_reset_q)
		|=> reg_rdata[BIT_SPEED_DOUBLE] == $past(reg_wdata[BIT_SPEED_DOUBLE], 2))
		else $error("speed bit readback wrong");
	// machine cycle spacing in fast mode
	mc_spacing_a: assert property (@(posedge clock) disable iff (!nrst)
		(mc_tick && six_mode && !sys_reset_q) ##1 (six_mode && !sys_reset_q) [*6]
		|-> mc_tick && !$past(mc_tick) && !$past(mc_tick, 5))
		else $error("machine cycle not six clocks");
	fuse_force_a: assert property (@(posedge clock) disable iff (!nrst)
		nv_speed_fuse |-> (six_clock_mode && rst_limit == RESET_OSC_6))
		else $error("fuse did not force fast mode");
	clkout_drive_a: assert property (@(posedge clock) disable iff (!nrst)
		clkout_pin_oe == (t2_mode_q[BIT_CLKOUT_EN] && !t2_control_q[BIT_COUNTER_SEL]))
		else $error("clock-out enable wrong");
	ext_count_a: assert property (@(posedge clock) disable iff (!nrst)
		(t2_tick && timer2_counter_select) |-> ($past(clkout_pin_in) && !clkout_pin_in))
		else $error("counter ticked without falling edge");
	// slow clock-out timebase every second clock
	fast_rate_a: assert property (@(posedge clock) disable iff (!nrst)
		(t2_tick && clkout_mode && !six_mode) |=> (!t2_tick || six_mode || sys_reset_q))
		else $error("slow clock-out counted on two clocks in a row");
	six_rate_a: assert property (@(posedge clock) disable iff (!nrst)
		(timer2_run && clkout_mode && six_mode) |-> t2_tick)
		else $error("fast clock-out skipped a clock");
	reload_value_a: assert property (@(posedge clock) disable iff (!nrst)
		(overflow && !reg_write && !sys_reset_q) |=> count_q == $past(reload_q))
		else $error("counter not reloaded");
	no_irq_a: assert property (@(posedge clock) disable iff (!nrst)
		(clkout_mode && !wr_t2_control) |=> !$rose(timer2_irq))
		else $error("interrupt flag rose in clock-out mode");
	baud_same_a: assert property (@(posedge clock) disable iff (!nrst)
		(overflow && baud_mode && !sys_reset_q) |=> baud_tick)
		else $error("baud tick missing on overflow");
	// reset needs twelve clocks of pin high at least
	reset_hold_a: assert property (@(posedge clock) disable iff (!nrst)
		$rose(sys_reset) |-> ($past(reset_pin, 1) && $past(reset_pin, 12)))
		else $error("reset taken on a short pulse");
	clkout_toggle_a: assert property (@(posedge clock) disable iff (!nrst)
		(overflow && clkout_mode && !sys_reset_q) |=> clkout_pin_out != $past(clkout_pin_out))
		else $error("clock-out did not toggle");

endmodule : clock_mode_and_clockout

// file: far_side.sv
`timescale 1ns/1ps
// Clock consumer and reset source on the far side of the pins
module far_side (
	input wire logic clock,
	input wire logic pin_out,
	input wire logic pin_oe,
	output logic pin_in,
	output logic reset_pin,
	output int hi_len,
	output int lo_len
);
	logic ext_q = 1'b1;
	logic lv_q = 1'b0;
	int run_q = 0;
	initial reset_pin = 1'b0;
	assign pin_in = pin_oe ? pin_out : ext_q;
	// Length of each high and low span of the pin
	always @(negedge clock)
	begin
		if (pin_in !== lv_q)
		begin
			if (lv_q)
				hi_len = run_q;
			else
				lo_len = run_q;
			run_q = 1;
			lv_q = pin_in;
		end
		else
			run_q++;
	end
	// reset pin high for n edges
	task hold_reset(input int n);
		@(posedge clock);
		reset_pin <= 1'b1;
		repeat (n) @(posedge clock);
		reset_pin <= 1'b0;
	endtask : hold_reset
	// count clock, w edges low and w+1 high per pulse
	task ext_pulses(input int n, input int w);
		repeat (n)
		begin
			@(posedge clock);
			ext_q <= 1'b0;
			repeat (w) @(posedge clock);
			ext_q <= 1'b1;
			repeat (w) @(posedge clock);
		end
	endtask : ext_pulses
endmodule : far_side

// file: clock_mode_and_clockout_tb_top.sv
`timescale 1ns/1ps
module clock_mode_and_clockout_tb_top;
	import clkmode_pkg::*;
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic fuse = 1'b0;
	logic [7:0] reg_rdata, d;
	logic reset_pin, sys_reset, six, mtick, btick, irq, pin_in, pin_out, pin_oe;
	logic [15:0] r;
	logic [7:0] mdl [logic [7:0]];
	logic [7:0] addrs [9] = '{ADDR_CLOCK_CTRL, ADDR_T2_MODE, ADDR_RELOAD_LOW,
		ADDR_RELOAD_HIGH, 8'h00, 8'hce, ADDR_T2_CONTROL, ADDR_COUNT_LOW, ADDR_COUNT_HIGH};
	int n_mismatch = 0;
	int compares = 0;
	int g;
	bit seen_rst;
	initial forever #12.5 clock = ~clock;
	clock_mode_and_clockout u_dut (.clock(clock), .nrst(nrst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
		.reg_rdata(reg_rdata), .nv_speed_fuse(fuse), .reset_pin(reset_pin),
		.sys_reset(sys_reset), .six_clock_mode(six), .machine_tick(mtick),
		.baud_tick(btick), .timer2_irq(irq), .clkout_pin_in(pin_in),
		.clkout_pin_out(pin_out), .clkout_pin_oe(pin_oe));
	far_side u_far (.clock(clock), .pin_out(pin_out), .pin_oe(pin_oe), .pin_in(pin_in),
		.reset_pin(reset_pin), .hi_len(), .lo_len());
	// Note any qualified reset
	always @(negedge clock) if (sys_reset === 1'b1) seen_rst = 1'b1;
	// Writable bits of each register
	function logic [7:0] mask(input logic [7:0] a);
		case (a)
			ADDR_CLOCK_CTRL: return CLOCK_CTRL_MASK;
			ADDR_T2_MODE: return MODE_MASK;
			ADDR_T2_CONTROL, ADDR_RELOAD_LOW, ADDR_RELOAD_HIGH: return 8'hff;
			ADDR_COUNT_LOW, ADDR_COUNT_HIGH: return 8'hff;
			default: return 8'h00;
		endcase
	endfunction : mask
	function logic tk(input bit b);
		return b ? btick : mtick;
	endfunction : tk
	task cmp_val(input logic [15:0] got, input logic [15:0] exp, input string m);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask : cmp_val
	task wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= v;
		reg_write <= 1'b1;
		@(posedge clock);
		reg_write <= 1'b0;
		mdl[a] = v & mask(a);
	endtask : wr
	task rd_chk(input logic [7:0] a);
		@(posedge clock);
		reg_addr <= a;
		reg_read <= 1'b1;
		@(posedge clock);
		reg_read <= 1'b0;
		#1 d = reg_rdata;
		cmp_val({8'h00, d}, {8'h00, mdl.exists(a) ? mdl[a] : 8'h00}, "register");
	endtask : rd_chk
	// Cycles between two pulses of a tick
	task gap(input bit b, output int n);
		int k;
		k = 0;
		do @(negedge clock); while (tk(b) !== 1'b1 && k++ < 9000);
		n = 0;
		do
		begin
			@(negedge clock);
			n++;
		end
		while (tk(b) !== 1'b1 && n < 9000);
	endtask : gap
	task end_of_test;
		$display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	// Watchdog
	initial
	begin
		#2000000;
		n_mismatch++;
		end_of_test;
	end
	// Main sequence
	initial
	begin
		void'($urandom(91));
		repeat (5) @(posedge clock);
		nrst <= 1'b1;
		foreach (addrs[i]) rd_chk(addrs[i]);
		for (int i = 0; i < 6; i++) wr(addrs[i], 8'($urandom));
		foreach (addrs[i]) rd_chk(addrs[i]);
		$display("registers done");
		for (int m = 0; m < 4; m++)
		begin
			wr(ADDR_CLOCK_CTRL, 8'(m & 1));
			fuse <= m[1];
			gap(0, g);
			gap(0, g);
			cmp_val(16'(g), (m == 0) ? 16'd12 : 16'd6, "machine cycle");
			cmp_val({15'h0, six}, {15'h0, m != 0}, "mode");
		end
		fuse <= 1'b0;
		$display("clock modes done");
		for (int s = 0; s < 2; s++)
		begin
			r = 16'hffc0 + 16'($urandom % 60);
			wr(ADDR_CLOCK_CTRL, 8'(s));
			wr(ADDR_RELOAD_LOW, r[7:0]);
			wr(ADDR_RELOAD_HIGH, r[15:8]);
			wr(ADDR_COUNT_LOW, r[7:0]);
			wr(ADDR_COUNT_HIGH, r[15:8]);
			wr(ADDR_T2_MODE, 8'h02);
			wr(ADDR_T2_CONTROL, 8'h34);
			repeat (6) gap(1, g);
			cmp_val(16'(g), 16'((2 - s) * (65536 - r)), "baud gap");
			cmp_val(16'(u_far.hi_len), 16'((2 - s) * (65536 - r)), "high span");
			cmp_val(16'(u_far.lo_len), 16'((2 - s) * (65536 - r)), "low span");
			cmp_val({14'h0, pin_oe, irq}, 16'h0002, "drive and flag");
			rd_chk(ADDR_T2_CONTROL);
			wr(ADDR_T2_CONTROL, 8'h00);
		end
		$display("clock-out done");
		wr(ADDR_T2_MODE, 8'h00);
		wr(ADDR_COUNT_LOW, 8'h00);
		wr(ADDR_COUNT_HIGH, 8'h00);
		wr(ADDR_T2_CONTROL, 8'h06);
		g = 3 + $urandom % 10;
		u_far.ext_pulses(g, 3);
		wr(ADDR_T2_CONTROL, 8'h00);
		mdl[ADDR_COUNT_LOW] = 8'(g);
		rd_chk(ADDR_COUNT_LOW);
		rd_chk(ADDR_COUNT_HIGH);
		// Plain timer mode: machine ticks overflow and raise the flag
		wr(ADDR_COUNT_LOW, 8'hfe);
		wr(ADDR_COUNT_HIGH, 8'hff);
		wr(ADDR_T2_CONTROL, 8'h04);
		repeat (20) @(posedge clock);
		#1 cmp_val({14'h0, pin_oe, irq}, 16'h0001, "timer flag");
		mdl[ADDR_T2_CONTROL] = 8'h84;
		rd_chk(ADDR_T2_CONTROL);
		wr(ADDR_T2_CONTROL, 8'h00);
		#1 cmp_val({15'h0, irq}, 16'h0000, "flag clear");
		$display("external count done");
		for (int s = 0; s < 2; s++)
		begin
			wr(ADDR_CLOCK_CTRL, 8'(s));
			seen_rst = 1'b0;
			u_far.hold_reset(s ? 11 : 23);
			repeat (3) @(posedge clock);
			cmp_val({15'h0, seen_rst}, 16'h0000, "short reset");
			u_far.hold_reset(s ? 14 : 26);
			repeat (3) @(posedge clock);
			cmp_val({15'h0, seen_rst}, 16'h0001, "full reset");
			mdl.delete();
			rd_chk(ADDR_CLOCK_CTRL);
			rd_chk(ADDR_RELOAD_LOW);
		end
		$display("reset pin done");
		end_of_test;
	end
endmodule : clock_mode_and_clockout_tb_top
